// file: qec_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------------
// Shared constants of the encoder counter channel.
// ----------------------------------------------------------------------------
package qec_pkg;
  // Data path widths and buffering.
  localparam int CNT_W      = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W     = 8;

  // Register byte offsets on the APB side.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RELOAD = 8'h04;
  localparam logic [7:0] ADDR_CMD    = 8'h08;
  localparam logic [7:0] ADDR_SNAP   = 8'h0c;
  localparam logic [7:0] ADDR_STAT   = 8'h10;
  localparam logic [7:0] ADDR_COUNT  = 8'h14;

  // Control register fields.
  localparam int CTRL_EN       = 0;
  localparam int CTRL_FUNC_LSB = 1;
  localparam int CTRL_DEC_LSB  = 3;
  localparam int CTRL_RD_LSB   = 5;
  localparam int CTRL_ZA       = 7;
  localparam int CTRL_ZB       = 8;
  localparam int CTRL_ZEN      = 9;
  localparam int CTRL_EXTTRIG  = 10;
  localparam int CTRL_TOUT     = 11;
  localparam int CTRL_W        = 12;
  localparam logic [11:0] CTRL_RESET   = 12'h000;
  localparam logic [31:0] RELOAD_RESET = 32'h0000_0000;

  // Command and status bits.
  localparam int CMD_SWTRIG = 0;
  localparam int CMD_LATCH  = 1;
  localparam int STAT_RUN   = 0;
  localparam int STAT_EMPTY = 1;
  localparam int STAT_FULL  = 2;
  localparam int STAT_LOST  = 3;

  // Pin vector positions in the input synchroniser.
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_Z = 2;
  localparam int PIN_G = 3;
  localparam int PIN_S = 4;
  localparam int PIN_T = 5;
  localparam int PIN_N = 6;

  // Trigger output pulse: 1 us at a 4 ns clock.
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int TRIG_PULSE_NS  = 1000;
  localparam int TRIG_PULSE_CYC = (TRIG_PULSE_NS * 1000) / CLK_PERIOD_PS;
  localparam int TRIG_W         = $clog2(TRIG_PULSE_CYC + 1);

  typedef enum logic [1:0] {
    QEC_FN_QUAD = 2'h0, QEC_FN_TWO = 2'h1, QEC_FN_FREQ = 2'h2
  } qec_func_t;
  typedef enum logic [1:0] {
    QEC_DEC_SINGLE = 2'h0, QEC_DEC_DOUBLE = 2'h1, QEC_DEC_QUAD = 2'h2
  } qec_dec_t;
  typedef enum logic [1:0] {
    QEC_RD_SINGLE = 2'h0, QEC_RD_SAMPLE = 2'h1, QEC_RD_IMPLICIT = 2'h2
  } qec_rd_t;
  typedef enum logic [1:0] {
    QEC_ST_IDLE = 2'h0, QEC_ST_ARMED = 2'h1, QEC_ST_RUN = 2'h3
  } qec_state_t;
endpackage : qec_pkg
`default_nettype wire

// file: qec_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Flip-flop FIFO with valid and ready on both sides.
// ----------------------------------------------------------------------------
module qec_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  // Clock, reset and enable.
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // Filling side.
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side.
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  // Status.
  output logic              full,
  output logic              empty
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW:0]  wr_reg;
  logic [AW:0]  wr_next;
  logic [AW:0]  rd_reg;
  logic [AW:0]  rd_next;
  logic         push;
  logic         pop;

  // Full is told apart from empty by the extra pointer wrap bit.
  assign empty     = (wr_reg == rd_reg);
  assign full      = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && (wr_reg[AW] != rd_reg[AW]);
  assign in_ready  = ce && !full;
  assign out_valid = !empty;
  assign out_data  = mem_reg[rd_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  // Pointer next values.
  always_comb begin
    wr_next = push ? wr_reg + (AW+1)'(1) : wr_reg;
    rd_next = pop ? rd_reg + (AW+1)'(1) : rd_reg;
  end

  // Pointer registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else if (ce) begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // Storage has no reset; only written words are ever shown.
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_reg[wr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule : qec_fifo
`default_nettype wire

// file: qec_counter.sv
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module qec_counter #(
  parameter int CNT_W      = qec_pkg::CNT_W,
  parameter int FIFO_DEPTH = qec_pkg::FIFO_DEPTH
) (
  // Clock, reset and enable.
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // APB slave.
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Encoder, gate and system pins.
  input  wire logic             enc_a,
  input  wire logic             enc_b,
  input  wire logic             enc_z,
  input  wire logic             gate_in,
  input  wire logic             samp_clk_in,
  input  wire logic             ext_trig_in,
  output logic                  ext_trig_out,
  // Result stream toward the host.
  output logic                  st_valid,
  input  wire logic             st_ready,
  output logic [CNT_W-1:0]      st_data
);
  // --------------------------------------------------------------------------
  // Declarations.
  // --------------------------------------------------------------------------
  localparam int TW = qec_pkg::TRIG_W;

  logic [qec_pkg::PIN_N-1:0]  s1_reg, s2_reg, d_reg;
  logic [qec_pkg::CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [CNT_W-1:0]           reload_reg, reload_next, snap_reg, snap_next;
  logic [CNT_W-1:0]           count_reg, count_next, meas_reg, meas_next;
  logic [CNT_W-1:0]           period_reg, period_next, pend_data_reg, pend_data_next;
  logic [31:0]                prdata_next;
  logic                       lost_reg, lost_next, pend_reg, pend_next;
  logic                       gseen_reg, gseen_next, mfrozen_reg, mfrozen_next;
  logic [TW-1:0]              timer_reg, timer_next;
  logic                       tout_next;
  qec_pkg::qec_state_t        state_reg, state_next;
  qec_pkg::qec_func_t         func;
  qec_pkg::qec_dec_t          dec;
  qec_pkg::qec_rd_t           rdm;
  logic                       wr_en, rd_setup, addr_ok;
  logic                       a_s, b_s, z_s, a_rise, a_fall, b_rise, b_fall;
  logic                       g_rise, s_rise, t_rise, trig, trig_fire, run;
  logic                       cnt_up, cnt_dn, zrst, meas_done, push_req;
  logic [CNT_W-1:0]           push_data;
  logic                       f_ready, f_full, f_empty;

  // --------------------------------------------------------------------------
  // Pin synchroniser and edge detect.
  // --------------------------------------------------------------------------
  // Only the second and third stages feed the edge detectors, so a metastable first
  // stage never reaches the counting logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      d_reg  <= '0;
    end else if (ce) begin
      s1_reg <= {ext_trig_in, samp_clk_in, gate_in, enc_z, enc_b, enc_a};
      s2_reg <= s1_reg;
      d_reg  <= s2_reg;
    end
  end

  // Edges are taken on the synchronised copies only.
  assign a_s    = s2_reg[qec_pkg::PIN_A];
  assign b_s    = s2_reg[qec_pkg::PIN_B];
  assign z_s    = s2_reg[qec_pkg::PIN_Z];
  assign a_rise = a_s && !d_reg[qec_pkg::PIN_A];
  assign a_fall = !a_s && d_reg[qec_pkg::PIN_A];
  assign b_rise = b_s && !d_reg[qec_pkg::PIN_B];
  assign b_fall = !b_s && d_reg[qec_pkg::PIN_B];
  assign g_rise = s2_reg[qec_pkg::PIN_G] && !d_reg[qec_pkg::PIN_G];
  assign s_rise = s2_reg[qec_pkg::PIN_S] && !d_reg[qec_pkg::PIN_S];
  assign t_rise = s2_reg[qec_pkg::PIN_T] && !d_reg[qec_pkg::PIN_T];

  // --------------------------------------------------------------------------
  // APB register file.
  // --------------------------------------------------------------------------
  assign func = qec_pkg::qec_func_t'(ctrl_reg[qec_pkg::CTRL_FUNC_LSB +: 2]);
  assign dec  = qec_pkg::qec_dec_t'(ctrl_reg[qec_pkg::CTRL_DEC_LSB +: 2]);
  assign rdm  = qec_pkg::qec_rd_t'(ctrl_reg[qec_pkg::CTRL_RD_LSB +: 2]);

  // The bus stalls while the block is frozen; a read whose setup cycle falls in the freeze returns the old prdata.
  assign pready   = ce;
  assign addr_ok  = paddr inside {qec_pkg::ADDR_CTRL, qec_pkg::ADDR_RELOAD, qec_pkg::ADDR_CMD,
                                  qec_pkg::ADDR_SNAP, qec_pkg::ADDR_STAT, qec_pkg::ADDR_COUNT};
  assign pslverr  = psel && penable && !addr_ok;
  assign wr_en    = ce && psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;

  // Register writes, read data capture and the lost flag.
  always_comb begin
    ctrl_next   = ctrl_reg;
    reload_next = reload_reg;
    snap_next   = snap_reg;
    prdata_next = prdata;
    lost_next   = lost_reg;
    if (wr_en && paddr == qec_pkg::ADDR_CTRL) begin
      ctrl_next = pwdata[qec_pkg::CTRL_W-1:0];
    end
    if (wr_en && paddr == qec_pkg::ADDR_RELOAD) begin
      reload_next = pwdata[CNT_W-1:0];
    end
    // Writing one clears the lost flag; a new loss in that cycle wins.
    if (wr_en && paddr == qec_pkg::ADDR_STAT && pwdata[qec_pkg::STAT_LOST]) begin
      lost_next = 1'b0;
    end
    if (push_req && pend_reg && !f_ready) begin
      lost_next = 1'b1;
    end
    // The host request latches the value it will read back.
    if (wr_en && paddr == qec_pkg::ADDR_CMD && pwdata[qec_pkg::CMD_LATCH]) begin
      snap_next = (func == qec_pkg::QEC_FN_FREQ) ? meas_reg : count_reg;
    end
    if (rd_setup) begin
      unique case (paddr)
        qec_pkg::ADDR_CTRL:   prdata_next = 32'(ctrl_reg);
        qec_pkg::ADDR_RELOAD: prdata_next = 32'(reload_reg);
        qec_pkg::ADDR_SNAP:   prdata_next = 32'(snap_reg);
        qec_pkg::ADDR_STAT:   prdata_next = 32'({lost_reg, f_full, f_empty, run});
        qec_pkg::ADDR_COUNT:  prdata_next = 32'(count_reg);
        default:              prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= qec_pkg::CTRL_RESET;
      reload_reg <= CNT_W'(qec_pkg::RELOAD_RESET);
      snap_reg   <= '0;
      prdata     <= 32'h0000_0000;
      lost_reg   <= 1'b0;
    end else if (ce) begin
      ctrl_reg   <= ctrl_next;
      reload_reg <= reload_next;
      snap_reg   <= snap_next;
      prdata     <= prdata_next;
      lost_reg   <= lost_next;
    end
  end

  // --------------------------------------------------------------------------
  // Trigger, decode and measurement core.
  // --------------------------------------------------------------------------
  assign run  = (state_reg == qec_pkg::QEC_ST_RUN);
  assign trig = ctrl_reg[qec_pkg::CTRL_EXTTRIG] ? t_rise
              : (wr_en && paddr == qec_pkg::ADDR_CMD && pwdata[qec_pkg::CMD_SWTRIG]);
  assign trig_fire = (state_reg == qec_pkg::QEC_ST_ARMED) && ctrl_reg[qec_pkg::CTRL_EN] && trig;
  assign zrst = run && ctrl_reg[qec_pkg::CTRL_ZEN] && z_s
             && a_s == ctrl_reg[qec_pkg::CTRL_ZA] && b_s == ctrl_reg[qec_pkg::CTRL_ZB];
  assign meas_done = run && (func == qec_pkg::QEC_FN_FREQ) && g_rise && gseen_reg;

  // Direction decode; up and down on one cycle cancel.
  always_comb begin
    cnt_up = 1'b0;
    cnt_dn = 1'b0;
    if (func == qec_pkg::QEC_FN_TWO) begin
      cnt_up = a_rise;
      cnt_dn = b_rise;
    end else if (func == qec_pkg::QEC_FN_QUAD) begin
      unique case (dec)
        qec_pkg::QEC_DEC_SINGLE: begin
          cnt_up = a_rise && !b_s;
          cnt_dn = a_fall && !b_s;
        end
        qec_pkg::QEC_DEC_DOUBLE: begin
          cnt_up = (a_rise || a_fall) && (a_s != b_s);
          cnt_dn = (a_rise || a_fall) && (a_s == b_s);
        end
        qec_pkg::QEC_DEC_QUAD: begin
          cnt_up = ((a_rise || a_fall) && (a_s != b_s))
                || ((b_rise || b_fall) && (a_s == b_s));
          cnt_dn = ((a_rise || a_fall) && (a_s == b_s))
                || ((b_rise || b_fall) && (a_s != b_s));
        end
        default: begin
          cnt_up = 1'b0;
          cnt_dn = 1'b0;
        end
      endcase
    end
  end

  // Pushes: sample ticks carry the live count (the held period in frequency mode), implicit mode the period.
  always_comb begin
    push_req  = 1'b0;
    push_data = count_reg;
    if (run && rdm == qec_pkg::QEC_RD_SAMPLE && s_rise) begin
      push_req  = 1'b1;
      push_data = (func == qec_pkg::QEC_FN_FREQ) ? meas_reg : count_reg;
    end else if (rdm == qec_pkg::QEC_RD_IMPLICIT && meas_done) begin
      push_req  = 1'b1;
      push_data = period_reg + CNT_W'(1);
    end
  end

  // State, counter, period and trigger output next values.
  always_comb begin
    state_next     = state_reg;
    count_next     = count_reg;
    period_next    = period_reg;
    meas_next      = meas_reg;
    gseen_next     = gseen_reg;
    mfrozen_next   = mfrozen_reg;
    pend_next      = pend_reg;
    pend_data_next = pend_data_reg;
    timer_next     = (timer_reg != '0) ? timer_reg - TW'(1) : timer_reg;
    unique case (state_reg)
      qec_pkg::QEC_ST_IDLE:  if (ctrl_reg[qec_pkg::CTRL_EN]) state_next = qec_pkg::QEC_ST_ARMED;
      qec_pkg::QEC_ST_ARMED: begin
        if (!ctrl_reg[qec_pkg::CTRL_EN]) begin
          state_next = qec_pkg::QEC_ST_IDLE;
        end else if (trig_fire) begin
          state_next   = qec_pkg::QEC_ST_RUN;
          count_next   = reload_reg;
          gseen_next   = 1'b0;
          mfrozen_next = 1'b0;
          if (ctrl_reg[qec_pkg::CTRL_TOUT]) begin
            timer_next = TW'(qec_pkg::TRIG_PULSE_CYC);
          end
        end
      end
      qec_pkg::QEC_ST_RUN:   if (!ctrl_reg[qec_pkg::CTRL_EN]) state_next = qec_pkg::QEC_ST_IDLE;
      default:               state_next = qec_pkg::QEC_ST_IDLE;
    endcase
    if (zrst) begin
      count_next = reload_reg;
    end else if (run && cnt_up && !cnt_dn) begin
      count_next = count_reg + CNT_W'(1);
    end else if (run && cnt_dn && !cnt_up) begin
      count_next = count_reg - CNT_W'(1);
    end
    // The period counter restarts at each gate rise.
    if (run && func == qec_pkg::QEC_FN_FREQ) begin
      period_next = g_rise ? '0 : period_reg + CNT_W'(1);
      if (g_rise) begin
        gseen_next = 1'b1;
      end
    end
    // Single-point mode keeps only the first period after the trigger.
    if (meas_done && !mfrozen_reg) begin
      meas_next    = period_reg + CNT_W'(1);
      mfrozen_next = (rdm == qec_pkg::QEC_RD_SINGLE);
    end
    // One holding slot absorbs a stalled FIFO; a second push then is lost.
    if (pend_reg && f_ready) begin
      pend_next = 1'b0;
    end
    if (push_req && (!pend_reg || f_ready)) begin
      pend_next      = 1'b1;
      pend_data_next = push_data;
    end
    tout_next = (timer_next != '0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= qec_pkg::QEC_ST_IDLE;
      count_reg     <= '0;
      period_reg    <= '0;
      meas_reg      <= '0;
      gseen_reg     <= 1'b0;
      mfrozen_reg   <= 1'b0;
      pend_reg      <= 1'b0;
      pend_data_reg <= '0;
      timer_reg     <= '0;
      ext_trig_out  <= 1'b0;
    end else if (ce) begin
      state_reg     <= state_next;
      count_reg     <= count_next;
      period_reg    <= period_next;
      meas_reg      <= meas_next;
      gseen_reg     <= gseen_next;
      mfrozen_reg   <= mfrozen_next;
      pend_reg      <= pend_next;
      pend_data_reg <= pend_data_next;
      timer_reg     <= timer_next;
      ext_trig_out  <= tout_next;
    end
  end

  // --------------------------------------------------------------------------
  // Result FIFO toward the host.
  // --------------------------------------------------------------------------
  qec_fifo #(
    .W     (CNT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .in_valid  (pend_reg),
    .in_ready  (f_ready),
    .in_data   (pend_data_reg),
    .out_valid (st_valid),
    .out_ready (st_ready),
    .out_data  (st_data),
    .full      (f_full),
    .empty     (f_empty)
  );

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_single_up: assert property (ce && run && func == qec_pkg::QEC_FN_QUAD && !zrst
    && dec == qec_pkg::QEC_DEC_SINGLE && a_rise && !b_s |=> count_reg == $past(count_reg) + 1)
    else $error("single edge count did not step up");
  a_single_down: assert property (ce && run && func == qec_pkg::QEC_FN_QUAD && !zrst
    && dec == qec_pkg::QEC_DEC_SINGLE && a_fall && !b_s |=> count_reg == $past(count_reg) - 1)
    else $error("single edge count did not step down");
  a_double_down: assert property (ce && run && func == qec_pkg::QEC_FN_QUAD && !zrst
    && dec == qec_pkg::QEC_DEC_DOUBLE && a_fall && !b_s |=> count_reg == $past(count_reg) - 1)
    else $error("double edge count did not step down");
  a_quad_bedge: assert property (ce && run && func == qec_pkg::QEC_FN_QUAD && !zrst
    && dec == qec_pkg::QEC_DEC_QUAD && b_rise && a_s && !a_rise && !a_fall
    |=> count_reg == $past(count_reg) + 1)
    else $error("quad edge count ignored a b edge");
  a_two_pulse: assert property (ce && run && func == qec_pkg::QEC_FN_TWO && !zrst
    && b_rise && !a_rise |=> count_reg == $past(count_reg) - 1)
    else $error("two pulse count did not step down");
  a_index_load: assert property (ce && zrst |=> count_reg == $past(reload_reg))
    else $error("index reload lost to a count edge");
  a_single_quiet: assert property (rdm == qec_pkg::QEC_RD_SINGLE |-> !push_req)
    else $error("single point mode pushed a value");
  a_sample_push: assert property (ce && push_req && !pend_reg
    |=> pend_reg && pend_data_reg == $past(push_data))
    else $error("sampling tick push not captured");
  a_period_value: assert property (ce && meas_done && rdm == qec_pkg::QEC_RD_IMPLICIT
    && !pend_reg |=> pend_data_reg == $past(period_reg) + 1)
    else $error("period result not pushed");
  a_trig_start: assert property ($rose(ext_trig_out) |-> $past(trig_fire))
    else $error("trigger pulse without a trigger");
  a_trig_width: assert property ($fell(ext_trig_out) |-> $past(timer_reg) == 1)
    else $error("trigger pulse width wrong");

  c_quad_count: cover property (run && dec == qec_pkg::QEC_DEC_QUAD && cnt_up);
  c_index_load: cover property (zrst && (cnt_up || cnt_dn));
  c_fifo_full:  cover property (f_full && push_req);
  c_trig_pulse: cover property ($fell(ext_trig_out));
endmodule : qec_counter
`default_nettype wire

// file: qec_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Encoder, gate and sampling-tick source for the counter channel.
// ----------------------------------------------------------------------------
module qec_enc_model (
  // Bench clock.
  input  wire logic pclk,
  // Encoder phases, index, gate and sampling tick.
  output logic      a,
  output logic      b,
  output logic      z,
  output logic      g,
  output logic      s
);
  // Idle levels; the gate stays low until gper drives a period.
  initial begin
    a = 1'b0;
    b = 1'b0;
    z = 1'b0;
    g = 1'b0;
    s = 1'b0;
  end

  // Each level holds eight clocks, well past the pin synchroniser delay.
  task automatic put(input logic na, input logic nb, input logic nz);
    @(posedge pclk);
    a <= na;
    b <= nb;
    z <= nz;
    repeat (7) @(posedge pclk);
  endtask : put

  // One full encoder cycle; forward means phase A leads phase B.
  task automatic cyc(input logic fwd);
    put(fwd, !fwd, 1'b0);
    put(1'b1, 1'b1, 1'b0);
    put(!fwd, fwd, 1'b0);
    put(1'b0, 1'b0, 1'b0);
  endtask : cyc

  // One pulse on a two-pulse channel, then back to idle.
  task automatic pulse(input logic na, input logic nb);
    put(na, nb, 1'b0);
    put(1'b0, 1'b0, 1'b0);
  endtask : pulse

  // One gate period of p clocks; successive calls space the rises p clocks apart.
  task automatic gper(input int p);
    @(posedge pclk);
    g <= 1'b1;
    repeat (p / 2) @(posedge pclk);
    g <= 1'b0;
    repeat (p - p / 2 - 1) @(posedge pclk);
  endtask : gper

  // One tick of the shared sampling clock.
  task automatic tick;
    @(posedge pclk);
    s <= 1'b1;
    repeat (7) @(posedge pclk);
    s <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : tick
endmodule : qec_enc_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // --------------------------------------------------------------------------
  // Bench signals.
  // --------------------------------------------------------------------------
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, st_data, rd;
  logic        enc_a, enc_b, enc_z, gate_in, samp_clk_in, ext_trig_in;
  logic        ext_trig_out, st_valid, st_ready;
  int          n_mismatch, cmp_count, n;

  qec_counter DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .enc_a, .enc_b, .enc_z, .gate_in, .samp_clk_in,
    .ext_trig_in, .ext_trig_out, .st_valid, .st_ready, .st_data);
  qec_enc_model ENC (.pclk, .a(enc_a), .b(enc_b), .z(enc_z), .g(gate_in), .s(samp_clk_in));

  // 250 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // --------------------------------------------------------------------------
  // Compare, bus and verdict tasks.
  // --------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // The idle edge at the start keeps two transfers from touching psel in one step.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input string nm, input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(nm, exp, rd);
  endtask : rdc

  // Let the host drain the stream and count the words that leave.
  task automatic drain(input string nm, input int exp);
    st_ready <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge pclk);
      if (st_valid === 1'b1 && st_ready === 1'b1)
        n++;
    end
    chk(nm, 32'(exp), 32'(n));
  endtask : drain

  // Disarm, load the reload value, arm with the given control word and trigger.
  task automatic go(input logic [31:0] c, input logic [31:0] r);
    apb(1'b1, qec_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, qec_pkg::ADDR_RELOAD, r);
    apb(1'b1, qec_pkg::ADDR_CTRL, c);
    apb(1'b1, qec_pkg::ADDR_CMD, 32'h1);
  endtask : go

  task automatic results;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // Watchdog sized well above the whole sequence.
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    results();
  end

  // --------------------------------------------------------------------------
  // Test sequence.
  // --------------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, ext_trig_in, st_ready} = 6'h0;
    ce = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", qec_pkg::ADDR_CTRL, 32'h0);
    rdc("reload", qec_pkg::ADDR_RELOAD, 32'h0);
    rdc("stat", qec_pkg::ADDR_STAT, 32'h2);
    apb(1'b0, 8'hfc, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    // Single, double and quad decoding: two cycles forward, one back.
    for (int d = 0; d < 3; d++) begin
      go(32'(1 | (d << 3)), 32'd100);
      ENC.cyc(1'b1);
      ENC.cyc(1'b1);
      rdc("fwd", qec_pkg::ADDR_COUNT, 32'(100 + 2 * (1 << d)));
      ENC.cyc(1'b0);
      rdc("rev", qec_pkg::ADDR_COUNT, 32'(100 + (1 << d)));
    end
    // Two-pulse: two up pulses, one down pulse.
    go(32'h3, 32'd100);
    ENC.pulse(1'b1, 1'b0);
    ENC.pulse(1'b1, 1'b0);
    ENC.pulse(1'b0, 1'b1);
    rdc("two pulse", qec_pkg::ADDR_COUNT, 32'd101);
    // A pulse that comes and goes while the block is frozen is never seen.
    ce <= 1'b0;
    ENC.pulse(1'b1, 1'b0);
    ce <= 1'b1;
    rdc("frozen", qec_pkg::ADDR_COUNT, 32'd101);
    // Index on A1B0 together with an A rise, then an A fall steps down.
    go(32'h281, 32'd7);
    ENC.cyc(1'b1);
    ENC.cyc(1'b1);
    ENC.put(1'b1, 1'b0, 1'b1);
    ENC.put(1'b0, 1'b0, 1'b0);
    rdc("index", qec_pkg::ADDR_COUNT, 32'd6);
    // Single point: latch, move on, nothing streams.
    go(32'h1, 32'd40);
    ENC.cyc(1'b1);
    apb(1'b1, qec_pkg::ADDR_CMD, 32'h2);
    ENC.cyc(1'b1);
    ENC.tick();
    rdc("snap", qec_pkg::ADDR_SNAP, 32'd41);
    chk("no stream", 32'h0, {31'h0, st_valid});
    // Sampling mode with a stalled host: fill until a value is lost, then drain.
    go(32'h21, 32'h55);
    repeat (18) ENC.tick();
    rdc("stat full", qec_pkg::ADDR_STAT, 32'hd);
    chk("data", 32'h55, st_data);
    drain("pops", qec_pkg::FIFO_DEPTH + 1);
    rdc("stat empty", qec_pkg::ADDR_STAT, 32'hb);
    apb(1'b1, qec_pkg::ADDR_STAT, 32'h8);
    rdc("stat clear", qec_pkg::ADDR_STAT, 32'h3);
    // External trigger input starts the run and the output pulse.
    apb(1'b1, qec_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, qec_pkg::ADDR_CTRL, 32'hc01);
    ext_trig_in <= 1'b1;
    n = 0;
    repeat (300) begin
      @(posedge pclk);
      if (ext_trig_out === 1'b1)
        n++;
    end
    chk("trig pulse", 32'(qec_pkg::TRIG_PULSE_CYC), n);
    // Frequency with implicit buffering: three gate rises give two periods.
    st_ready <= 1'b0;
    go(32'h45, 32'h0);
    repeat (3) ENC.gper(20);
    chk("period", 32'd20, st_data);
    rdc("stat freq", qec_pkg::ADDR_STAT, 32'h1);
    apb(1'b1, qec_pkg::ADDR_CMD, 32'h2);
    rdc("snap freq", qec_pkg::ADDR_SNAP, 32'd20);
    drain("freq pops", 2);
    results();
  end
endmodule : tb_top
`default_nettype wire
